// ===== dv/pcd_link_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// link side of the register port
// ------------------------------------------------------------
module pcd_link_model #(
    parameter logic [5:0] IFC_ADDR = 6'h07,
    parameter logic [5:0] OTG_ADDR = 6'h0a,
    parameter logic [7:0] PULLUP_BIT = 8'h01
) (
    input wire logic ref_clk,
    output logic [5:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_we,
    output logic reg_re,
    input wire logic [7:0] reg_rdata
);
    initial begin
        reg_addr = 6'h00;
        reg_wdata = 8'h00;
        reg_we = 1'b0;
        reg_re = 1'b0;
    end
    // released lines show the inverse so a stale value never looks valid
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_we <= 1'b1;
        @(posedge ref_clk);
        reg_we <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask : wr
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_re <= 1'b1;
        @(posedge ref_clk);
        reg_re <= 1'b0;
        reg_addr <= ~a;
        #1;
        d = reg_rdata;
    endtask : rd
    // pull-up first, then routing, mode bit last; the mode register lies outside the block
    task automatic enter_uart(input logic [7:0] routing);
        wr(OTG_ADDR, PULLUP_BIT);
        wr(pcd_pkg::ADDR_UART, routing);
        wr(IFC_ADDR, 8'h08);
    endtask : enter_uart
endmodule : pcd_link_model

// ===== dv/tb_phy_carkit_debug_register_bank.sv
`timescale 1ns/1ps
module tb_phy_carkit_debug_register_bank;
    localparam int MC = 20;
    logic ref_clk;
    logic rst;
    logic [5:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic reg_we;
    logic reg_re;
    logic [1:0] line_state_pin;
    logic ident_open_pin;
    logic data0_pin;
    logic dp_pin;
    logic [2:0] meas_code_in;
    logic id_pin_o;
    logic id_pin_oe;
    logic dm_o;
    logic dm_oe;
    logic data1_o;
    logic measure_run;
    logic alt_int;
    int n_errors = 0;
    int n_compared = 0;
    int n_alt = 0;
    int n_run = 0;
    int n0;
    logic [7:0] v;
    // ------------------------------------------------------------
    // harness
    // ------------------------------------------------------------
    pcd_regs #(.MEAS_CYCLES(MC)) i_dut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
        .line_state_pin(line_state_pin), .ident_open_pin(ident_open_pin),
        .data0_pin(data0_pin), .dp_pin(dp_pin), .meas_code_in(meas_code_in),
        .id_pin_o(id_pin_o), .id_pin_oe(id_pin_oe), .dm_o(dm_o), .dm_oe(dm_oe),
        .data1_o(data1_o), .measure_run(measure_run), .alt_int(alt_int));
    pcd_link_model i_link (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata));
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        if (alt_int === 1'b1) n_alt++;
        if (measure_run === 1'b1) n_run++;
    end
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : step
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : chk
    task automatic rc(input logic [5:0] a, input logic [7:0] exp);
        i_link.rd(a, v);
        chk(v, exp, $sformatf("read %h", a));
    endtask : rc
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : tally_and_finish
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        chk(data1_o, 8'h01, "data1 idle");
        chk({id_pin_oe, dm_oe}, 8'h00, "drives idle");
        rc(pcd_pkg::ADDR_UART, 8'h00);
        rc(pcd_pkg::ADDR_IEN, 8'h00);
        rc(pcd_pkg::ADDR_SCRATCH, 8'h00);
        rc(6'h07, 8'h00);
        $display("reset values done");
    endtask : t_reset
    task automatic t_scratch();
        i_link.wr(6'h16, 8'ha5);
        rc(6'h16, 8'ha5);
        i_link.wr(6'h17, 8'h0a);
        rc(6'h18, 8'haf);
        i_link.wr(6'h18, 8'h03);
        rc(6'h17, 8'hac);
        chk({id_pin_oe, dm_oe, data1_o}, 8'h01, "side effect");
        $display("scratch done");
    endtask : t_scratch
    task automatic t_debug();
        for (int i = 0; i < 4; i++) begin
            @(posedge ref_clk) line_state_pin <= 2'(i);
            step(3);
            rc(pcd_pkg::ADDR_DEBUG, 8'(i));
        end
        $display("debug done");
    endtask : t_debug
    task automatic t_uart();
        i_link.enter_uart(8'hff);
        rc(pcd_pkg::ADDR_UART, 8'h0e);
        chk({id_pin_oe, id_pin_o}, 8'h02, "ground drive");
        for (int i = 0; i < 2; i++) begin
            @(posedge ref_clk) data0_pin <= 1'(i);
            @(posedge ref_clk) dp_pin <= 1'(i);
            step(4);
            chk({dm_oe, dm_o}, 8'(2 + i), "dm route");
            chk(data1_o, 8'(i), "data1 route");
        end
        i_link.wr(6'h1b, 8'h08);
        @(posedge ref_clk) dp_pin <= 1'b0;
        step(4);
        chk(data1_o, 8'h01, "data1 held");
        i_link.wr(6'h1b, 8'h06);
        rc(6'h1a, 8'h00);
        $display("uart routing done");
    endtask : t_uart
    task automatic t_ident();
        i_link.wr(pcd_pkg::ADDR_IEN, 8'hff);
        rc(6'h1f, 8'h23);
        n0 = n_alt;
        @(posedge ref_clk) ident_open_pin <= 1'b1;
        step(6);
        chk(8'(n_alt - n0), 8'h01, "open rise");
        rc(pcd_pkg::ADDR_ISTAT, 8'h01);
        i_link.wr(pcd_pkg::ADDR_ISTAT, 8'hfe);
        rc(pcd_pkg::ADDR_ISTAT, 8'h01);
        rc(pcd_pkg::ADDR_LATCH, 8'h01);
        rc(pcd_pkg::ADDR_LATCH, 8'h00);
        i_link.wr(6'h1f, 8'h01);
        n0 = n_alt;
        @(posedge ref_clk) ident_open_pin <= 1'b0;
        step(6);
        chk(8'(n_alt - n0), 8'h01, "open fall");
        rc(pcd_pkg::ADDR_LATCH, 8'h01);
        i_link.wr(6'h1f, 8'h02);
        n0 = n_alt;
        @(posedge ref_clk) ident_open_pin <= 1'b1;
        step(6);
        @(posedge ref_clk) ident_open_pin <= 1'b0;
        step(6);
        chk(8'(n_alt - n0), 8'h00, "masked edges");
        $display("ident events done");
    endtask : t_ident
    task automatic t_measure();
        int k;
        logic [7:0] ien;
        for (int i = 0; i < 8; i++) begin
            if (i == 6) continue;
            ien = (i % 2 == 1) ? 8'h40 : 8'h00;
            @(posedge ref_clk) meas_code_in <= 3'(i);
            i_link.wr(pcd_pkg::ADDR_IEN, (i % 2 == 1) ? 8'h00 : 8'h20);
            n0 = n_alt;
            n_run = 0;
            i_link.wr(pcd_pkg::ADDR_VRID, 8'h10 | ien);
            k = 0;
            step(2);
            while (measure_run === 1'b1 && k < MC + 8) begin
                step(1);
                k++;
            end
            if (k >= MC + 8) begin
                n_errors++;
                $display("[ERR] %0t measurement never ended", $time);
                tally_and_finish();
            end
            step(2);
            chk(8'(n_run), 8'(MC), "run length");
            chk(8'(n_alt - n0), 8'h01, "done event");
            rc(pcd_pkg::ADDR_ISTAT, 8'h40 | 8'(i << 3));
            rc(pcd_pkg::ADDR_ISTAT, 8'h40 | 8'(i << 3));
            rc(pcd_pkg::ADDR_LATCH, 8'h08);
            rc(pcd_pkg::ADDR_VRID, 8'h08 | ien | 8'(i));
            rc(pcd_pkg::ADDR_ISTAT, 8'(i << 3));
        end
        $display("measurement done");
    endtask : t_measure
    // start through the set address, then abandon the run through the clear address
    task automatic t_abort();
        n0 = n_alt;
        i_link.wr(6'h37, 8'h10);
        step(4);
        chk(measure_run, 8'h01, "set starts run");
        i_link.wr(6'h38, 8'h10);
        step(MC + 4);
        chk(measure_run, 8'h00, "abort stops run");
        chk(8'(n_alt - n0), 8'h00, "abort no event");
        rc(pcd_pkg::ADDR_ISTAT, 8'h38);
        $display("abort done");
    endtask : t_abort
    // reset lands in the middle of a running measurement
    task automatic t_rerun();
        i_link.wr(pcd_pkg::ADDR_VRID, 8'h10);
        step(4);
        chk(measure_run, 8'h01, "run before reset");
        @(posedge ref_clk) rst <= 1'b1;
        step(3);
        @(posedge ref_clk) rst <= 1'b0;
        step(1);
        chk(measure_run, 8'h00, "run after reset");
        chk({alt_int, data1_o}, 8'h01, "outputs after reset");
        rc(pcd_pkg::ADDR_SCRATCH, 8'h00);
        rc(pcd_pkg::ADDR_IEN, 8'h00);
        rc(pcd_pkg::ADDR_VRID, 8'h00);
        rc(pcd_pkg::ADDR_ISTAT, 8'h00);
        $display("second reset done");
    endtask : t_rerun
    initial begin
        rst = 1'b1;
        line_state_pin = 2'b00;
        ident_open_pin = 1'b0;
        data0_pin = 1'b0;
        dp_pin = 1'b0;
        meas_code_in = 3'h0;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        step(1);
        t_reset();
        t_scratch();
        t_debug();
        t_uart();
        t_ident();
        t_measure();
        t_abort();
        t_rerun();
        tally_and_finish();
    end
endmodule : tb_phy_carkit_debug_register_bank

// ===== hw/pcd_pkg.sv
package pcd_pkg;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [5:0] ADDR_DEBUG = 6'h15;
    localparam logic [5:0] ADDR_SCRATCH = 6'h16;
    localparam logic [5:0] ADDR_UART = 6'h19;
    localparam logic [5:0] ADDR_IEN = 6'h1d;
    localparam logic [5:0] ADDR_ISTAT = 6'h20;
    localparam logic [5:0] ADDR_LATCH = 6'h21;
    localparam logic [5:0] ADDR_VRID = 6'h36;
    // ------------------------------------------------------------
    // field positions and writable masks
    // ------------------------------------------------------------
    localparam logic [7:0] UART_WMASK = 8'h0e;
    localparam logic [7:0] IEN_WMASK = 8'h23;
    localparam logic [7:0] VRID_WMASK = 8'h70;
    localparam int UART_GND = 1;
    localparam int UART_TX = 2;
    localparam int UART_RX = 3;
    localparam int IEN_RISE = 0;
    localparam int IEN_FALL = 1;
    localparam int IEN_RID = 5;
    localparam int VRID_GO = 4;
    localparam int VRID_IEN = 6;
    localparam int LATCH_FLOAT = 0;
    localparam int LATCH_RID = 3;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int MEAS_TIME_NS = 282000;
    localparam int CLK_PERIOD_NS = 8;
    localparam int MEAS_CYCLES = (MEAS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {PCD_WR = 2'b00, PCD_SET = 2'b01, PCD_CLR = 2'b10} pcd_op_t;
    typedef enum logic {PCD_IDLE = 1'b0, PCD_RUN = 1'b1} pcd_meas_t;

    function automatic logic [7:0] pcd_apply(input logic [7:0] old, input logic [7:0] data,
                                             input pcd_op_t op);
        unique case (op)
            PCD_WR: pcd_apply = data;
            PCD_SET: pcd_apply = old | data;
            default: pcd_apply = old & ~data;
        endcase
    endfunction : pcd_apply
endpackage : pcd_pkg

// ===== hw/pcd_regs.sv
`timescale 1ns/1ps
module pcd_regs #(
    parameter int MEAS_CYCLES = pcd_pkg::MEAS_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [5:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_we,
    input wire logic reg_re,
    output logic [7:0] reg_rdata,
    input wire logic [1:0] line_state_pin,
    input wire logic ident_open_pin,
    input wire logic data0_pin,
    input wire logic dp_pin,
    input wire logic [2:0] meas_code_in,
    output logic id_pin_o,
    output logic id_pin_oe,
    output logic dm_o,
    output logic dm_oe,
    output logic data1_o,
    output logic measure_run,
    output logic alt_int
);
    localparam int CW = $clog2(MEAS_CYCLES + 1);

    generate
        if (MEAS_CYCLES < 1) begin : g_bad
            $error("MEAS_CYCLES must be at least 1");
        end
    endgenerate

    function automatic logic hit(input logic [5:0] a, input logic [5:0] base);
        hit = (a >= base) && (a <= base + 6'h02);
    endfunction : hit

    function automatic pcd_pkg::pcd_op_t op_of(input logic [5:0] a, input logic [5:0] base);
        logic [5:0] d;
        d = a - base;
        op_of = pcd_pkg::pcd_op_t'(d[1:0]);
    endfunction : op_of

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [7:0] sync1_q, sync2_q;
    logic [1:0] ls_s;
    logic open_s, data0_s, dp_s;
    logic [2:0] code_s;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sync1_q <= 8'h00;
            sync2_q <= 8'h00;
        end else begin
            sync1_q <= {meas_code_in, dp_pin, data0_pin, ident_open_pin, line_state_pin};
            sync2_q <= sync1_q;
        end
    end
    assign ls_s = sync2_q[1:0];
    assign open_s = sync2_q[2];
    assign data0_s = sync2_q[3];
    assign dp_s = sync2_q[4];
    assign code_s = sync2_q[7:5];

    // ------------------------------------------------------------
    // registers and measurement
    // ------------------------------------------------------------
    logic [7:0] scratch_q, scratch_d, uart_q, uart_d, ien_q, ien_d, vrid_q, vrid_d;
    logic [7:0] latch_q, latch_d, rdata_q, rdata_d;
    logic [2:0] code_q, code_d;
    logic done_q, done_d, open_prev_q, alt_q, alt_d, dm_q, data1_q, data1_d;
    logic [CW-1:0] cnt_q, cnt_d;
    pcd_pkg::pcd_meas_t meas_q, meas_d;
    logic fin, float_evt, rid_evt, rid_en;

    assign rid_en = ien_q[pcd_pkg::IEN_RID] | vrid_q[pcd_pkg::VRID_IEN];
    assign float_evt = (ien_q[pcd_pkg::IEN_RISE] & open_s & ~open_prev_q)
                     | (ien_q[pcd_pkg::IEN_FALL] & ~open_s & open_prev_q);
    assign fin = (meas_q == pcd_pkg::PCD_RUN) && vrid_q[pcd_pkg::VRID_GO] && (cnt_q == '0);
    assign rid_evt = fin & ~done_q & rid_en;

    always_comb begin
        scratch_d = scratch_q;
        uart_d = uart_q;
        ien_d = ien_q;
        vrid_d = vrid_q;
        meas_d = meas_q;
        cnt_d = cnt_q;
        code_d = code_q;
        done_d = done_q;
        latch_d = latch_q;
        if (reg_we && hit(reg_addr, pcd_pkg::ADDR_SCRATCH)) begin
            scratch_d = pcd_pkg::pcd_apply(scratch_q, reg_wdata,
                                           op_of(reg_addr, pcd_pkg::ADDR_SCRATCH));
        end
        if (reg_we && hit(reg_addr, pcd_pkg::ADDR_UART)) begin
            uart_d = pcd_pkg::pcd_apply(uart_q, reg_wdata,
                                        op_of(reg_addr, pcd_pkg::ADDR_UART)) & pcd_pkg::UART_WMASK;
        end
        if (reg_we && hit(reg_addr, pcd_pkg::ADDR_IEN)) begin
            ien_d = pcd_pkg::pcd_apply(ien_q, reg_wdata,
                                       op_of(reg_addr, pcd_pkg::ADDR_IEN)) & pcd_pkg::IEN_WMASK;
        end
        if (reg_we && hit(reg_addr, pcd_pkg::ADDR_VRID)) begin
            vrid_d = pcd_pkg::pcd_apply(vrid_q, reg_wdata,
                                        op_of(reg_addr, pcd_pkg::ADDR_VRID)) & pcd_pkg::VRID_WMASK;
        end
        // clearing go mid-run abandons the measurement without a result
        unique case (meas_q)
            pcd_pkg::PCD_IDLE: begin
                if (vrid_q[pcd_pkg::VRID_GO]) begin
                    meas_d = pcd_pkg::PCD_RUN;
                    cnt_d = CW'(MEAS_CYCLES - 1);
                end
            end
            pcd_pkg::PCD_RUN: begin
                if (!vrid_q[pcd_pkg::VRID_GO] || fin) begin
                    meas_d = pcd_pkg::PCD_IDLE;
                end else begin
                    cnt_d = cnt_q - CW'(1);
                end
            end
        endcase
        if (reg_re && hit(reg_addr, pcd_pkg::ADDR_VRID)) begin
            done_d = 1'b0;
        end
        if (fin) begin
            vrid_d[pcd_pkg::VRID_GO] = 1'b0;
            code_d = code_s;
            done_d = 1'b1;
        end
        if (reg_re && reg_addr == pcd_pkg::ADDR_LATCH) begin
            latch_d = pcd_pkg::RESET_BYTE;
        end
        // a new event in the reading cycle is kept
        if (float_evt) begin
            latch_d[pcd_pkg::LATCH_FLOAT] = 1'b1;
        end
        if (rid_evt) begin
            latch_d[pcd_pkg::LATCH_RID] = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // read path and pin outputs
    // ------------------------------------------------------------
    always_comb begin
        rdata_d = rdata_q;
        if (reg_re) begin
            if (reg_addr == pcd_pkg::ADDR_DEBUG) begin
                rdata_d = {6'h00, ls_s};
            end else if (hit(reg_addr, pcd_pkg::ADDR_SCRATCH)) begin
                rdata_d = scratch_q;
            end else if (hit(reg_addr, pcd_pkg::ADDR_UART)) begin
                rdata_d = uart_q;
            end else if (hit(reg_addr, pcd_pkg::ADDR_IEN)) begin
                rdata_d = ien_q;
            end else if (reg_addr == pcd_pkg::ADDR_ISTAT) begin
                rdata_d = {1'b0, done_q, code_q, 2'b00, open_s};
            end else if (reg_addr == pcd_pkg::ADDR_LATCH) begin
                rdata_d = latch_q;
            end else if (hit(reg_addr, pcd_pkg::ADDR_VRID)) begin
                rdata_d = vrid_q | {4'h0, done_q, code_q};
            end else begin
                rdata_d = 8'h00;
            end
        end
        alt_d = float_evt | rid_evt;
        // link must set routing before entering uart mode; idle-high keeps rx quiet
        data1_d = uart_q[pcd_pkg::UART_RX] ? dp_s : 1'b1;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            scratch_q <= pcd_pkg::RESET_BYTE;
            uart_q <= pcd_pkg::RESET_BYTE;
            ien_q <= pcd_pkg::RESET_BYTE;
            vrid_q <= pcd_pkg::RESET_BYTE;
            latch_q <= pcd_pkg::RESET_BYTE;
            rdata_q <= pcd_pkg::RESET_BYTE;
            code_q <= 3'h0;
            done_q <= 1'b0;
            open_prev_q <= 1'b0;
            alt_q <= 1'b0;
            dm_q <= 1'b0;
            data1_q <= 1'b1;
            cnt_q <= '0;
            meas_q <= pcd_pkg::PCD_IDLE;
        end else begin
            scratch_q <= scratch_d;
            uart_q <= uart_d;
            ien_q <= ien_d;
            vrid_q <= vrid_d;
            latch_q <= latch_d;
            rdata_q <= rdata_d;
            code_q <= code_d;
            done_q <= done_d;
            open_prev_q <= open_s;
            alt_q <= alt_d;
            dm_q <= data0_s;
            data1_q <= data1_d;
            cnt_q <= cnt_d;
            meas_q <= meas_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign id_pin_o = 1'b0;
    assign id_pin_oe = uart_q[pcd_pkg::UART_GND];
    assign dm_o = dm_q;
    assign dm_oe = uart_q[pcd_pkg::UART_TX];
    assign data1_o = data1_q;
    assign measure_run = (meas_q == pcd_pkg::PCD_RUN);
    assign alt_int = alt_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    property p_debug;
        reg_re && reg_addr == pcd_pkg::ADDR_DEBUG |=> reg_rdata == {6'h00, $past(ls_s)};
    endproperty
    a_debug: assert property (p_debug) else $error("debug read wrong");
    property p_scr_set;
        reg_we && reg_addr == pcd_pkg::ADDR_SCRATCH + 6'h01
            |=> scratch_q == ($past(scratch_q) | $past(reg_wdata));
    endproperty
    a_scr_set: assert property (p_scr_set) else $error("scratch set wrong");
    property p_scr_clr;
        reg_we && reg_addr == pcd_pkg::ADDR_SCRATCH + 6'h02
            |=> scratch_q == ($past(scratch_q) & ~$past(reg_wdata));
    endproperty
    a_scr_clr: assert property (p_scr_clr) else $error("scratch clear wrong");
    property p_uart_rsv;
        (uart_q & ~pcd_pkg::UART_WMASK) == 8'h00 && (ien_q & ~pcd_pkg::IEN_WMASK) == 8'h00;
    endproperty
    a_uart_rsv: assert property (p_uart_rsv) else $error("reserved bit set");
    property p_rx_idle;
        !uart_q[pcd_pkg::UART_RX] ##1 !uart_q[pcd_pkg::UART_RX] |-> data1_o;
    endproperty
    a_rx_idle: assert property (p_rx_idle) else $error("data1 not high");
    property p_tx_route;
        dm_oe |-> ##1 dm_o == $past(data0_s);
    endproperty
    a_tx_route: assert property (p_tx_route) else $error("dm route wrong");
    property p_rx_route;
        uart_q[pcd_pkg::UART_RX] |=> data1_o == $past(dp_s);
    endproperty
    a_rx_route: assert property (p_rx_route) else $error("data1 route wrong");
    property p_float_irq;
        ien_q[pcd_pkg::IEN_RISE] && $rose(open_s) |=> alt_int ##0 latch_q[pcd_pkg::LATCH_FLOAT];
    endproperty
    a_float_irq: assert property (p_float_irq) else $error("float edge missed");
    property p_rid_irq;
        fin && !done_q && rid_en |=> alt_int && done_q;
    endproperty
    a_rid_irq: assert property (p_rid_irq) else $error("done irq missed");
    property p_conv_time;
        $rose(measure_run) |-> measure_run [*8];
    endproperty
    a_conv_time: assert property (p_conv_time) else $error("measure too short");
    property p_done_keep;
        reg_re && reg_addr == pcd_pkg::ADDR_ISTAT && done_q |=> done_q;
    endproperty
    a_done_keep: assert property (p_done_keep) else $error("status read cleared done");
    property p_go_clr;
        fin |=> !vrid_q[pcd_pkg::VRID_GO] && !measure_run;
    endproperty
    a_go_clr: assert property (p_go_clr) else $error("go not cleared");
    property p_latch_clr;
        reg_re && reg_addr == pcd_pkg::ADDR_LATCH && !float_evt && !rid_evt |=> latch_q == 8'h00;
    endproperty
    a_latch_clr: assert property (p_latch_clr) else $error("latch not cleared");

    c_conv: cover property (fin ##1 alt_int);
    c_float: cover property ($fell(open_s) ##1 alt_int);
    c_uart: cover property (dm_oe && uart_q[pcd_pkg::UART_RX]);
endmodule : pcd_regs
